// File: src/gsn_pkg.sv
// Purpose: Shared constants and types for the pin control and notify block
// Assumes: 32-bit Avalon-MM register bus, byte addressing, one clock
// Notes: Register indices are kept as printed; byte address is index times four
package gsn_pkg;

    // ****************************************
    // Sizes
    // ****************************************
    localparam int unsigned PIN_W = 10;
    localparam int unsigned ADDR_W = 8;

    // ****************************************
    // Register indices
    // ****************************************
    localparam logic [ADDR_W-1:0] IDX_PIN_DIR = 8'h0d;
    localparam logic [ADDR_W-1:0] IDX_PIN_SET_STROBE = 8'h0e;
    localparam logic [ADDR_W-1:0] IDX_PIN_CLEAR_STROBE = 8'h0f;
    localparam logic [ADDR_W-1:0] IDX_PIN_LEVEL = 8'h10;
    localparam logic [ADDR_W-1:0] IDX_PIN_CHANGE_MASK = 8'h11;
    localparam logic [ADDR_W-1:0] IDX_NOTIFY_FORMAT_CTRL = 8'h12;
    localparam logic [ADDR_W-1:0] IDX_PIN_ALT_SEL = 8'h20;
    localparam logic [ADDR_W-1:0] IDX_IRQ_STATUS = 8'h21;
    localparam logic [ADDR_W-1:0] IDX_IRQ_MASK = 8'h22;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [PIN_W-1:0] RST_PIN_CHANGE_MASK = 10'h100;
    localparam logic [PIN_W-1:0] RST_PIN_DIR = 10'h000;
    localparam logic [PIN_W-1:0] RST_PIN_LEVEL = 10'h000;
    localparam logic [PIN_W-1:0] RST_PIN_ALT_SEL = 10'h000;
    localparam logic [1:0] RST_NOTIFY_FORMAT = 2'h0;
    localparam logic [2:0] RST_IRQ_MASK = 3'h0;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int unsigned FMT_CUSTOM_BIT = 0;
    localparam int unsigned FMT_BREAK_EN_BIT = 1;
    localparam int unsigned IRQ_SENT_BIT = 0;
    localparam int unsigned IRQ_PIN_CHG_BIT = 1;
    localparam int unsigned IRQ_BREAK_BIT = 2;

    // ****************************************
    // Packet constants
    // ****************************************
    localparam logic [7:0] STD_REQ_TYPE = 8'ha1;
    localparam logic [7:0] STD_NOTIFY_CODE = 8'h20;
    localparam logic [7:0] STD_IFACE_NUM = 8'h00;
    localparam logic [15:0] STD_LENGTH = 16'h0002;
    localparam logic [3:0] STD_PKT_LAST = 4'h9;
    localparam logic [3:0] CUST_PKT_LAST = 4'h4;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        GSN_IDLE = 2'b01,
        GSN_SEND = 2'b10
    } gsn_state_e;

    // Serial line status from the receiver, same clock
    typedef struct packed {
        logic overrun;   // One-cycle pulse
        logic parity;    // One-cycle pulse
        logic framing;   // One-cycle pulse
        logic brk_rx;    // One-cycle pulse on break received
        logic brk_state; // Level
        logic ring;      // Level
        logic dsr;       // Level
        logic dcd;       // Level
    } gsn_uart_s;

    // Notification byte stream toward the interrupt endpoint
    typedef struct packed {
        logic valid;
        logic last;
        logic [7:0] data;
    } gsn_pkt_s;

    typedef struct packed {
        logic [PIN_W-1:0] sync1;
        logic [PIN_W-1:0] sync2;
        logic [PIN_W-1:0] prev;
        logic [PIN_W-1:0] outv;
        logic [PIN_W-1:0] dir;
        logic [PIN_W-1:0] alt;
        logic [PIN_W-1:0] mask;
        logic [1:0] fmt;
        logic [PIN_W-1:0] chg;
        logic pend;
        logic [2:0] err_acc;
        logic [2:0] modem_prev;
        gsn_state_e st;
        logic [3:0] idx;
        logic [PIN_W-1:0] snap_pins;
        logic [PIN_W-1:0] snap_chg;
        logic [7:0] snap_line;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic ack;
        logic [31:0] rdata;
        logic [7:0] pkt_data;
    } gsn_state_s;

endpackage

// File: src/gsn_notify.sv
// Purpose: Ten-pin output control, change masking and notification packets
// Assumes: Avalon-MM slave with waitrequest, synchronous active-low reset
// Notes: Pins are sampled through two flops; packet goes out as a byte stream
`timescale 1ns/1ps

// Behaviour
// RQ1: set strobe ones drive outputs high
// RQ2: clear strobe ones drive outputs low
// RQ3: alternate-function pins ignore set and clear
// RQ4: input pins ignore set and clear
// RQ5: level read returns all ten pins
// RQ6: level write loads outputs directly
// RQ7: zero mask bit lets change notify
// RQ8: masking covers every input pin
// RQ9: masked pins still report true level
// RQ10: format bit1 enables break notification
// RQ11: format bit0 picks custom layout
// RQ12: standard header bytes A1 then 20
// RQ13: zero value, interface zero, length two
// RQ14: standard data word line status bits
// RQ15: custom packet: levels then change flags
// RQ16: custom status byte at offset four
// RQ17: direction bit one means output
// RQ18: change flags cleared after packet sent; code clears them when the packet snapshot is taken, before sending
// RQ19: software writes zeros to reserved bits
module gsn_notify
    import gsn_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [PIN_W-1:0] pin_in,
    output logic [PIN_W-1:0] pin_out,
    output logic [PIN_W-1:0] pin_oe,
    input wire logic [PIN_W-1:0] alt_out,
    input wire logic [PIN_W-1:0] alt_oe,
    input wire gsn_uart_s uart_line,
    output gsn_pkt_s pkt,
    input wire logic pkt_ready,
    output logic irq
);

    gsn_state_s cur_ff;
    gsn_state_s nxt_cur;

    // ****************************************
    // Bus decode
    // ****************************************
    logic [ADDR_W-1:0] reg_idx;
    logic wr_go;
    logic [PIN_W-1:0] wr_pins;
    logic [PIN_W-1:0] gpio_out_pins;
    logic [PIN_W-1:0] pin_edges;
    logic [PIN_W-1:0] input_pins;
    logic [2:0] modem_now;
    logic trig_pins;
    logic trig_break;
    logic trig_line;
    logic any_trig;
    logic pkt_done;
    logic [31:0] rd_mux;
    logic [7:0] std_byte;
    logic [7:0] cust_byte;

    // Byte address to register index; low two bits ignored as lanes are full words
    assign reg_idx = {2'b00, avs_address[ADDR_W-1:2]};
    // The write lands on the edge where waitrequest is seen low
    assign wr_go = avs_write && cur_ff.ack;
    assign wr_pins = avs_writedata[PIN_W-1:0];

    // Only plain outputs take strobes; alternate pins and inputs are shielded
    assign gpio_out_pins = cur_ff.dir & ~cur_ff.alt; // RQ3 RQ4 RQ17
    // A pin counts as input when nothing here drives it
    assign input_pins = ~pin_oe;
    assign pin_edges = (cur_ff.sync2 ^ cur_ff.prev) & input_pins;
    assign modem_now = {uart_line.ring, uart_line.dsr, uart_line.dcd};

    // ****************************************
    // Notification triggers
    // ****************************************
    assign trig_pins = |(pin_edges & ~cur_ff.mask); // RQ7 RQ8
    assign trig_break = uart_line.brk_rx && cur_ff.fmt[FMT_BREAK_EN_BIT]; // RQ10
    assign trig_line = uart_line.overrun || uart_line.parity || uart_line.framing
        || (modem_now != cur_ff.modem_prev);
    assign any_trig = trig_pins || trig_break || trig_line;
    assign pkt_done = (cur_ff.st == GSN_SEND) && pkt_ready && pkt.last;

    // ****************************************
    // Packet byte selection
    // ****************************************
    // Standard layout: fixed header, then the two-byte line status word
    always_comb begin
        case (cur_ff.idx)
            4'h0: std_byte = STD_REQ_TYPE; // RQ12
            4'h1: std_byte = STD_NOTIFY_CODE; // RQ12
            4'h4: std_byte = STD_IFACE_NUM; // RQ13
            4'h6: std_byte = STD_LENGTH[7:0]; // RQ13
            4'h7: std_byte = STD_LENGTH[15:8]; // RQ13
            4'h8: std_byte = {1'b0, cur_ff.snap_line[6:0]}; // RQ14
            default: std_byte = 8'h00; // RQ13 RQ14
        endcase
    end

    // Custom layout: pin levels, change flags, error and break-state byte
    always_comb begin
        case (cur_ff.idx)
            4'h0: cust_byte = cur_ff.snap_pins[7:0]; // RQ15
            4'h1: cust_byte = {6'h00, cur_ff.snap_pins[9:8]}; // RQ15
            4'h2: cust_byte = cur_ff.snap_chg[7:0]; // RQ15
            4'h3: cust_byte = {6'h00, cur_ff.snap_chg[9:8]}; // RQ15
            default: cust_byte = {4'h0, cur_ff.snap_line[6:4], cur_ff.snap_line[2]}; // RQ16
        endcase
    end

    // ****************************************
    // Register read mux
    // ****************************************
    // Unmapped addresses read as zero; reserved bits read as zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (reg_idx)
            IDX_PIN_DIR: rd_mux[PIN_W-1:0] = cur_ff.dir;
            IDX_PIN_LEVEL: rd_mux[PIN_W-1:0] = cur_ff.sync2; // RQ5 RQ9
            IDX_PIN_CHANGE_MASK: rd_mux[PIN_W-1:0] = cur_ff.mask;
            IDX_NOTIFY_FORMAT_CTRL: rd_mux[1:0] = cur_ff.fmt;
            IDX_PIN_ALT_SEL: rd_mux[PIN_W-1:0] = cur_ff.alt;
            IDX_IRQ_STATUS: rd_mux[2:0] = cur_ff.irq_stat;
            IDX_IRQ_MASK: rd_mux[2:0] = cur_ff.irq_mask;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        nxt_cur = cur_ff;

        // Two-flop pin synchroniser; only the second stage feeds logic
        nxt_cur.sync1 = pin_in;
        nxt_cur.sync2 = cur_ff.sync1;
        nxt_cur.prev = cur_ff.sync2;
        nxt_cur.modem_prev = modem_now;

        // Bus handshake: one wait cycle, then answer for one cycle
        nxt_cur.ack = (avs_read || avs_write) && !cur_ff.ack;
        if ((avs_read || avs_write) && !cur_ff.ack) begin
            nxt_cur.rdata = rd_mux;
        end

        // Register writes; upper bits are dropped on the floor
        if (wr_go) begin
            case (reg_idx)
                IDX_PIN_DIR: nxt_cur.dir = wr_pins; // RQ17
                IDX_PIN_SET_STROBE: begin
                    nxt_cur.outv = cur_ff.outv | (wr_pins & gpio_out_pins); // RQ1 RQ3 RQ4
                end
                IDX_PIN_CLEAR_STROBE: begin
                    nxt_cur.outv = cur_ff.outv & ~(wr_pins & gpio_out_pins); // RQ2 RQ3 RQ4
                end
                IDX_PIN_LEVEL: begin
                    nxt_cur.outv = (cur_ff.outv & ~gpio_out_pins)
                        | (wr_pins & gpio_out_pins); // RQ6
                end
                IDX_PIN_CHANGE_MASK: nxt_cur.mask = wr_pins; // RQ7
                IDX_NOTIFY_FORMAT_CTRL: nxt_cur.fmt = avs_writedata[1:0]; // RQ10 RQ11
                IDX_PIN_ALT_SEL: nxt_cur.alt = wr_pins;
                IDX_IRQ_MASK: nxt_cur.irq_mask = avs_writedata[2:0];
                default: nxt_cur.fmt = nxt_cur.fmt;
            endcase
        end

        // Accumulate error pulses until they are reported
        nxt_cur.err_acc = cur_ff.err_acc
            | {uart_line.overrun, uart_line.parity, uart_line.framing};
        // Change flags gather every input edge, masked or not
        nxt_cur.chg = cur_ff.chg | pin_edges; // RQ18
        if (any_trig) begin
            nxt_cur.pend = 1'b1;
        end

        // Packet sequencer
        case (cur_ff.st)
            GSN_IDLE: begin
                if (cur_ff.pend) begin
                    nxt_cur.st = GSN_SEND;
                    nxt_cur.idx = 4'h0;
                    nxt_cur.pend = any_trig;
                    // Snapshot so the packet stays self-consistent while it drains
                    nxt_cur.snap_pins = cur_ff.sync2; // RQ9
                    nxt_cur.snap_chg = cur_ff.chg;
                    nxt_cur.snap_line = {1'b0, cur_ff.err_acc, uart_line.ring,
                        uart_line.brk_state, uart_line.dsr, uart_line.dcd}; // RQ14
                    // Edges in this very cycle stay pending for the next packet
                    nxt_cur.chg = pin_edges; // RQ18
                    nxt_cur.err_acc = {uart_line.overrun, uart_line.parity,
                        uart_line.framing};
                end
            end
            GSN_SEND: begin
                if (pkt_ready) begin
                    if (pkt.last) begin
                        nxt_cur.st = GSN_IDLE;
                        nxt_cur.idx = 4'h0;
                    end else begin
                        nxt_cur.idx = cur_ff.idx + 4'h1;
                    end
                end
            end
            default: begin
                nxt_cur.st = GSN_IDLE;
                nxt_cur.idx = 4'h0;
            end
        endcase
        nxt_cur.pkt_data = cur_ff.fmt[FMT_CUSTOM_BIT] ? cust_byte : std_byte; // RQ11

        // Sticky events: a new event wins over a write-one clear
        if (wr_go && reg_idx == IDX_IRQ_STATUS) begin
            nxt_cur.irq_stat = cur_ff.irq_stat & ~avs_writedata[2:0];
        end
        if (pkt_done) begin
            nxt_cur.irq_stat[IRQ_SENT_BIT] = 1'b1;
        end
        if (trig_pins) begin
            nxt_cur.irq_stat[IRQ_PIN_CHG_BIT] = 1'b1;
        end
        if (trig_break) begin
            nxt_cur.irq_stat[IRQ_BREAK_BIT] = 1'b1;
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cur_ff <= '0;
            cur_ff.outv <= RST_PIN_LEVEL;
            cur_ff.dir <= RST_PIN_DIR; // RQ17
            cur_ff.alt <= RST_PIN_ALT_SEL;
            cur_ff.mask <= RST_PIN_CHANGE_MASK; // RQ7
            cur_ff.fmt <= RST_NOTIFY_FORMAT; // RQ11
            cur_ff.irq_mask <= RST_IRQ_MASK;
            cur_ff.st <= GSN_IDLE;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Alternate functions own their pins; plain pins follow direction
    assign pin_out = (cur_ff.alt & alt_out) | (~cur_ff.alt & cur_ff.outv);
    assign pin_oe = (cur_ff.alt & alt_oe) | (~cur_ff.alt & cur_ff.dir); // RQ17

    assign avs_waitrequest = (avs_read || avs_write) && !cur_ff.ack;
    assign avs_readdata = cur_ff.rdata;

    // Valid stands for the whole packet; bytes come from the registered index
    assign pkt.valid = (cur_ff.st == GSN_SEND);
    assign pkt.data = cur_ff.fmt[FMT_CUSTOM_BIT] ? cust_byte : std_byte;
    assign pkt.last = (cur_ff.st == GSN_SEND) && (cur_ff.idx ==
        (cur_ff.fmt[FMT_CUSTOM_BIT] ? CUST_PKT_LAST : STD_PKT_LAST)); // RQ13 RQ16

    assign irq = |(cur_ff.irq_stat & cur_ff.irq_mask);

endmodule

// File: sim/gsn_notify_monitor.sv
// Purpose: Port-level checks for the pin control and notify block
// Assumes: One clock, synchronous active-low reset
// Notes: A byte counter tracks the position inside a packet
`timescale 1ns/1ps
module gsn_notify_mon
    import gsn_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire gsn_pkt_s pkt,
    input wire logic pkt_ready,
    input wire logic [PIN_W-1:0] pin_oe,
    input wire logic irq
);
    // ****************************************
    // Helpers
    // ****************************************
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    int pos_ff;
    // Offset of the byte on offer; restarts after the last byte is taken
    always_ff @(posedge clock) begin
        if (!rst_n || (pkt.valid && pkt_ready && pkt.last)) begin
            pos_ff <= 0;
        end else if (pkt.valid && pkt_ready) begin
            pos_ff <= pos_ff + 1;
        end
    end
    sequence req_s;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence end_s;
        pkt.valid && pkt_ready && pkt.last;
    endsequence
    // ****************************************
    // Assertions
    // ****************************************
    wait_one_a: assert property (req_s |=> !avs_waitrequest)
        else $error("bus answer not one cycle after request");
    wake_quiet_a: assert property ($rose(rst_n) |-> !irq && !pkt.valid && pin_oe == '0)
        else $error("outputs not quiet after reset");
    pkt_hold_a: assert property (pkt.valid && !pkt_ready |=>
        pkt.valid && $stable(pkt.data) && $stable(pkt.last))
        else $error("byte changed before taken");
    pkt_gap_a: assert property (end_s |=> !pkt.valid)
        else $error("no idle cycle between packets");
    pkt_len_a: assert property (pkt.valid && pkt.last |-> pos_ff == 4 || pos_ff == 9)
        else $error("packet length wrong");
    std_data_a: assert property (pkt.valid && pos_ff == 8 |-> !pkt.data[7])
        else $error("reserved data bit set");
    std_tail_a: assert property (pkt.valid && pos_ff == 9 |-> pkt.last && pkt.data == 8'h00)
        else $error("standard tail byte wrong");
    cust_tail_a: assert property (end_s and pos_ff == 4 |-> pkt.data[7:4] == 4'h0)
        else $error("custom status upper bits set");
endmodule

// File: sim/gsn_host_sink.sv
// Purpose: Host-side sink for notification bytes
// Assumes: A byte is taken at an edge with valid and ready high
// Notes: Slow mode toggles ready so the device must hold each byte
`timescale 1ns/1ps
module gsn_host_sink
    import gsn_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire gsn_pkt_s pkt,
    input wire logic slow,
    output logic pkt_ready
);
    logic [7:0] rx_q[$];
    // Collect bytes; ready changes only just after an edge
    always @(posedge clock) begin
        if (!rst_n) begin
            pkt_ready <= 1'b1;
        end else begin
            pkt_ready <= slow ? !pkt_ready : 1'b1;
            if (pkt.valid && pkt_ready) begin
                rx_q.push_back(pkt.data);
            end
        end
    end
endmodule

// File: sim/gsn_tb.sv
// Purpose: Self-checking bench for the pin control and notify block
// Assumes: Avalon master waits for waitrequest low, host sink on the stream
// Notes: Reset reads first, then pin rows and notification cases
`timescale 1ns/1ps
module tb
    import gsn_pkg::*;
;
    typedef struct packed {logic [7:0] idx; logic [31:0] wd; logic [9:0] out; logic [9:0] oe;} gsn_row_s;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [9:0] pin_in = 10'h000;
    logic [9:0] pin_out;
    logic [9:0] pin_oe;
    logic [9:0] alt_out = 10'h2aa;
    logic [9:0] alt_oe = 10'h0c0;
    gsn_uart_s uart_line = '0;
    gsn_pkt_s pkt;
    logic pkt_ready;
    logic irq;
    logic slow = 1'b0;
    int fails = 0;
    int cmp_count = 0;
    // Pins 6,7 alternate, 8,9 input until the fifth row
    gsn_row_s rows[9] = '{'{8'h20, 32'h0c0, 10'h080, 10'h0c0}, '{8'h0d, 32'h0ff, 10'h080, 10'h0ff},
        '{8'h0e, 32'h3ff, 10'h0bf, 10'h0ff}, '{8'h0f, 32'h005, 10'h0ba, 10'h0ff},
        '{8'h0d, 32'h3ff, 10'h0ba, 10'h3ff}, '{8'h0e, 32'h200, 10'h2ba, 10'h3ff},
        '{8'h10, 32'h155, 10'h195, 10'h3ff}, '{8'h0f, 32'h000, 10'h195, 10'h3ff},
        '{8'h2c, 32'h3ff, 10'h195, 10'h3ff}};
    logic [7:0] rst_idx[6] = '{8'h11, 8'h12, 8'h0e, 8'h0d, 8'h10, 8'h2c};
    logic [31:0] rst_val[6] = '{32'h100, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

    gsn_notify i_dut (.clock(clock), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .alt_out(alt_out), .alt_oe(alt_oe),
        .uart_line(uart_line), .pkt(pkt), .pkt_ready(pkt_ready), .irq(irq));
    gsn_host_sink i_host (.clock(clock), .rst_n(rst_n), .pkt(pkt), .slow(slow),
        .pkt_ready(pkt_ready));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // Request is held until waitrequest is seen low at an edge; only the watchdog ends a hang
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
        output logic [31:0] rd);
        @(posedge clock);
        avs_address <= {idx[5:0], 2'b00};
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= wd;
        do begin
            @(posedge clock);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        logic [31:0] d;
        bus(1'b1, idx, wd, d);
    endtask
    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, idx, 32'h0, d);
        check(d, exp);
    endtask
    // Wait for n bytes at the host, with some idle time to catch extras
    task automatic pkt_chk(input int n, input logic [79:0] exp);
        int k;
        k = 0;
        while (i_host.rx_q.size() < n && k < 200) begin
            @(posedge clock);
            k++;
        end
        repeat (8) @(posedge clock);
        check(32'(i_host.rx_q.size()), 32'(n));
        for (int i = 0; i < n && i < i_host.rx_q.size(); i++) begin
            check(32'(i_host.rx_q[i]), 32'(exp[79-8*i -: 8]));
        end
        i_host.rx_q.delete();
    endtask
    task automatic pulse(input gsn_uart_s v);
        @(posedge clock);
        uart_line <= v;
        @(posedge clock);
        uart_line <= '0;
    endtask
    task automatic tally_and_finish();
        $display("counts: %0d compares, %0d mismatches", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ****************************************
    // Stimulus
    // ****************************************
    initial begin
        forever #2.5 clock = ~clock;
    end
    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        tally_and_finish();
    end
    initial begin
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        foreach (rst_idx[i]) rd_chk(rst_idx[i], rst_val[i]);
        $display("test reset values done");
        foreach (rows[i]) begin
            wr(rows[i].idx, rows[i].wd);
            @(negedge clock);
            check(32'(pin_out & pin_oe), 32'(rows[i].out));
            check(32'(pin_oe), 32'(rows[i].oe));
        end
        $display("test pin rows done");
        wr(8'h0d, 32'h0);
        wr(8'h20, 32'h0);
        wr(8'h22, 32'h7);
        wr(8'h11, 32'h3ff);
        slow <= 1'b1;
        pulse(8'h40);
        pkt_chk(10, 80'ha120_0000_0000_0200_2000);
        check(32'(irq), 32'h1);
        rd_chk(8'h21, 32'h1);
        wr(8'h21, 32'h1);
        wr(8'h22, 32'h0);
        pulse(8'h20);
        pkt_chk(10, 80'ha120_0000_0000_0200_1000);
        check(32'(irq), 32'h0);
        wr(8'h21, 32'h7);
        wr(8'h22, 32'h7);
        $display("test standard packets done");
        slow <= 1'b0;
        wr(8'h12, 32'h1);
        wr(8'h11, 32'h3fe);
        pin_in <= 10'h101;
        pkt_chk(5, {40'h0101010100, 40'h0});
        rd_chk(8'h21, 32'h3);
        wr(8'h21, 32'h3);
        rd_chk(8'h10, 32'h101);
        pulse(8'h20);
        pkt_chk(5, {40'h0101000002, 40'h0});
        pin_in <= 10'h001;
        pkt_chk(0, 80'h0);
        pulse(8'h10);
        pkt_chk(0, 80'h0);
        wr(8'h12, 32'h3);
        pulse(8'h10);
        pkt_chk(5, {40'h0100000100, 40'h0});
        $display("test custom packets done");
        tally_and_finish();
    end
endmodule

bind gsn_notify gsn_notify_mon i_mon (.clock(clock), .rst_n(rst_n), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .pkt(pkt),
    .pkt_ready(pkt_ready), .pin_oe(pin_oe), .irq(irq));
